// file: src/mcd_pkg.sv
// Shared constants, offsets and checksum helper for the motion command decoder
package mcd_pkg;

  localparam int         FRM_BYTES = 9;
  localparam int         AXIS_W    = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_FRAME0 = 8'h00;
  localparam logic [7:0] OFS_FRAME8 = 8'h20;
  localparam logic [7:0] OFS_ACCU   = 8'h24;
  localparam logic [7:0] OFS_XREG   = 8'h28;
  localparam logic [7:0] OFS_STAT   = 8'h2C;
  localparam logic [7:0] OFS_TARGET = 8'h30;
  localparam logic [7:0] OFS_COUNT  = 8'h34;

  // Status register fields
  localparam int         STAT_DROP_BIT = 0;
  localparam int         STAT_BUSY_BIT = 1;
  localparam int         STAT_CODE_LSB = 8;
  localparam int         STAT_INSTR_LSB = 16;

  // Reset values
  localparam logic [31:0] ACCU_RST = 32'h0000_0000;
  localparam logic [31:0] XREG_RST = 32'h0000_0000;

  // Instruction codes
  localparam logic [7:0] INS_MOVE_IDX  = 8'h2F;
  localparam logic [7:0] INS_DOWN_ACCU = 8'h32;
  localparam logic [7:0] INS_UP_ACCU   = 8'h33;
  localparam logic [7:0] INS_DOWN_IDX  = 8'h34;
  localparam logic [7:0] INS_UP_IDX    = 8'h35;

  // Move target types
  localparam logic [7:0] TGT_ABSOLUTE = 8'h00;
  localparam logic [7:0] TGT_OFFSET   = 8'h01;
  localparam logic [7:0] TGT_STORED   = 8'h02;

  // Axis parameter numbers
  localparam logic [7:0] PAR_TGT_POS = 8'h00;
  localparam logic [7:0] PAR_TGT_VEL = 8'h02;

  // Reply status codes and reply address
  localparam logic [7:0] STS_OK        = 8'h64;
  localparam logic [7:0] STS_BAD_SUM   = 8'h01;
  localparam logic [7:0] STS_BAD_CMD   = 8'h02;
  localparam logic [7:0] STS_BAD_TYPE  = 8'h03;
  localparam logic [7:0] STS_BAD_VALUE = 8'h04;
  localparam logic [7:0] HOST_ADDR     = 8'h02;

  // Modulo-256 sum of eight bytes
  function automatic logic [7:0] mcd_sum8(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + b[8*i +: 8];
    end
    return s;
  endfunction

endpackage

// file: src/mcd_link_if.sv
// Frame and reply carrier between receiver, core and reply builder
interface mcd_link_if;
  logic        frm_valid;
  logic [7:0]  frm_target;
  logic [7:0]  frm_instr;
  logic [7:0]  frm_type;
  logic [7:0]  frm_motor;
  logic [31:0] frm_value;
  logic        frm_sum_ok;
  logic        rep_done;
  logic [7:0]  rep_status;
  logic [7:0]  rep_instr;

  modport rx (output frm_valid, frm_target, frm_instr, frm_type,
              output frm_motor, frm_value, frm_sum_ok);
  modport core (input frm_valid, frm_target, frm_instr, frm_type,
                input frm_motor, frm_value, frm_sum_ok,
                output rep_done, rep_status, rep_instr);
  modport tx (input rep_done, rep_status, rep_instr);
endinterface

// file: src/mcd_frame_rx.sv
// Frame byte collector with checksum compare
module mcd_frame_rx (
  input  logic         ref_clk,
  input  logic         resetn,
  input  logic [7:0]   reg_addr,
  input  logic [7:0]   reg_wdata,
  input  logic         reg_wr,
  mcd_link_if.rx       lnk
);
  import mcd_pkg::*;

  logic [7:0] frame_mem [0:7];
  logic       byte_hit;
  logic [2:0] byte_idx;
  logic       last_hit;

  assign byte_hit = reg_wr && reg_addr < OFS_FRAME8 && reg_addr[1:0] == 2'b00;
  assign byte_idx = reg_addr[4:2];
  assign last_hit = reg_wr && reg_addr == OFS_FRAME8;

  // Byte order: address, instruction, type, motor, value msb..lsb
  always_ff @(posedge ref_clk) begin
    if (byte_hit) begin
      frame_mem[byte_idx] <= reg_wdata;
    end
  end

  // Checksum byte completes the frame
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lnk.frm_valid  <= 1'b0;
      lnk.frm_target <= 8'h00;
      lnk.frm_instr  <= 8'h00;
      lnk.frm_type   <= 8'h00;
      lnk.frm_motor  <= 8'h00;
      lnk.frm_value  <= 32'h0000_0000;
      lnk.frm_sum_ok <= 1'b0;
    end else begin
      lnk.frm_valid <= last_hit;
      if (last_hit) begin
        lnk.frm_target <= frame_mem[0];
        lnk.frm_instr  <= frame_mem[1];
        lnk.frm_type   <= frame_mem[2];
        lnk.frm_motor  <= frame_mem[3];
        lnk.frm_value  <= {frame_mem[4], frame_mem[5], frame_mem[6], frame_mem[7]};
        lnk.frm_sum_ok <= mcd_sum8({frame_mem[7], frame_mem[6], frame_mem[5],
                                    frame_mem[4], frame_mem[3], frame_mem[2],
                                    frame_mem[1], frame_mem[0]}) == reg_wdata;
      end
    end
  end
endmodule

// file: src/mcd_reply.sv
// Reply frame builder with checksum
module mcd_reply #(
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  input  logic                             ref_clk,
  input  logic                             resetn,
  mcd_link_if.tx                           lnk,
  output logic                             reply_valid,
  output logic [mcd_pkg::FRM_BYTES*8-1:0]  reply_frame
);
  import mcd_pkg::*;

  logic [63:0] head;

  // Value field carries no meaning, sent as zero
  assign head = {HOST_ADDR, MODULE_ADDR, lnk.rep_status, lnk.rep_instr, 32'h0000_0000};

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reply_valid <= 1'b0;
      reply_frame <= '0;
    end else begin
      reply_valid <= lnk.rep_done;
      if (lnk.rep_done) begin
        reply_frame <= {head, mcd_sum8(head)};
      end
    end
  end
endmodule

// file: src/mcd_decoder.sv
// Motion command decoder core with register port
//
// What this block does
// - Code 50 turns motor-field axis downward
// - Code 51 turns motor-field axis upward
// - Rotate selects velocity mode, then loads velocity
// - Velocity value means microsteps per second
// - Code 47 takes axis from X register
// - Move writes accumulator into target position
// - Type picks absolute, offset or stored point
// - Offset target adds value to actual position
// - Move replies at once, commands keep flowing
// - Rotate command abandons running positioning
// - Code 52 turns X-register axis downward
// - Code 53 turns X-register axis upward
// - Frame bytes: address, code, type, motor, value, sum
// - Every error-free command replies status 100 OK
//
// Strobed register access and the register offsets are this design's own decisions.
module mcd_decoder #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter int         AXES        = 6
) (
  input  logic                            ref_clk,
  input  logic                            resetn,
  input  logic [7:0]                      reg_addr,
  input  logic [31:0]                     reg_wdata,
  input  logic                            reg_wr,
  input  logic                            reg_rd,
  output logic [31:0]                     reg_rdata,
  input  logic [AXES*32-1:0]              act_pos_flat,
  input  logic [31:0]                     point_data,
  output logic [7:0]                      point_idx,
  output logic                            axis_vel_mode,
  output logic                            axis_dir_down,
  output logic                            pos_abort,
  output logic [mcd_pkg::AXIS_W-1:0]      axis_sel,
  output logic                            param_wr,
  output logic [7:0]                      param_num,
  output logic [31:0]                     param_data,
  output logic                            reply_valid,
  output logic [mcd_pkg::FRM_BYTES*8-1:0] reply_frame
);
  import mcd_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CHECK = 6'h02,
    ST_POINT = 6'h04,
    ST_MODE  = 6'h08,
    ST_LOAD  = 6'h10,
    ST_REPLY = 6'h20
  } mcd_state_type;

  mcd_state_type       state;
  mcd_state_type       next_state;
  logic [31:0]         accu;
  logic [31:0]         xreg;
  logic [7:0]          cur_instr;
  logic [7:0]          cur_type;
  logic [7:0]          cur_motor;
  logic                cur_sum_ok;
  logic [7:0]          last_status;
  logic [7:0]          last_instr;
  logic [15:0]         frame_count;
  logic                dropped;
  logic                frame_take;
  logic                is_move;
  logic                is_rot_accu;
  logic                is_rot_idx;
  logic                is_rot;
  logic                is_down;
  logic                axis_ok;
  logic                type_ok;
  logic [AXIS_W-1:0]   cmd_axis;
  logic [31:0]         act_sel;
  logic [7:0]          next_status;
  logic [31:0]         next_target;

  mcd_link_if lnk ();

  mcd_frame_rx u_rx (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata[7:0]),
    .reg_wr    (reg_wr),
    .lnk       (lnk.rx)
  );

  mcd_reply #(
    .MODULE_ADDR (MODULE_ADDR)
  ) u_tx (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .lnk         (lnk.tx),
    .reply_valid (reply_valid),
    .reply_frame (reply_frame)
  );

  // Frames for other addresses get no reply
  assign frame_take = lnk.frm_valid && state == ST_IDLE
                      && lnk.frm_target == MODULE_ADDR;

  // Command classification
  always_comb begin
    is_move     = cur_instr == INS_MOVE_IDX;
    is_rot_accu = cur_instr == INS_DOWN_ACCU || cur_instr == INS_UP_ACCU;
    is_rot_idx  = cur_instr == INS_DOWN_IDX || cur_instr == INS_UP_IDX;
    is_rot      = is_rot_accu || is_rot_idx;
    is_down     = cur_instr == INS_DOWN_ACCU || cur_instr == INS_DOWN_IDX;
    type_ok     = !is_move || cur_type <= TGT_STORED;
    if (is_rot_accu) begin
      cmd_axis = cur_motor[AXIS_W-1:0];
      axis_ok  = 32'(cur_motor) < 32'(AXES);
    end else begin
      cmd_axis = xreg[AXIS_W-1:0];
      axis_ok  = xreg < 32'(AXES);
    end
    act_sel = act_pos_flat[32*int'(cmd_axis) +: 32];
  end

  // Error priority: checksum, code, type, axis
  always_comb begin
    if (!cur_sum_ok) begin
      next_status = STS_BAD_SUM;
    end else if (!is_move && !is_rot) begin
      next_status = STS_BAD_CMD;
    end else if (!type_ok) begin
      next_status = STS_BAD_TYPE;
    end else if (!axis_ok) begin
      next_status = STS_BAD_VALUE;
    end else begin
      next_status = STS_OK;
    end
  end

  // Position target; wraps at 32 bits, as the 16-bit frame counter wraps at 16
  always_comb begin
    if (state == ST_POINT) begin
      next_target = point_data;
    end else if (cur_type == TGT_OFFSET) begin
      next_target = act_sel + accu;
    end else begin
      next_target = accu;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_take) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (next_status != STS_OK) begin
          next_state = ST_REPLY;
        end else if (is_rot) begin
          next_state = ST_MODE;
        end else if (cur_type == TGT_STORED) begin
          next_state = ST_POINT;
        end else begin
          next_state = ST_LOAD;
        end
      end
      ST_POINT: next_state = ST_LOAD;
      ST_MODE:  next_state = ST_LOAD;
      ST_LOAD:  next_state = ST_REPLY;
      ST_REPLY: next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latch the accepted frame fields
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur_instr  <= 8'h00;
      cur_type   <= 8'h00;
      cur_motor  <= 8'h00;
      cur_sum_ok <= 1'b0;
    end else if (frame_take) begin
      cur_instr  <= lnk.frm_instr;
      cur_type   <= lnk.frm_type;
      cur_motor  <= lnk.frm_motor;
      cur_sum_ok <= lnk.frm_sum_ok;
    end
  end

  // Strobes toward the ramp generator and parameter store
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      axis_vel_mode <= 1'b0;
      pos_abort     <= 1'b0;
      param_wr      <= 1'b0;
    end else begin
      axis_vel_mode <= next_state == ST_MODE;
      pos_abort     <= next_state == ST_MODE;
      param_wr      <= next_state == ST_LOAD;
    end
  end

  // Axis, direction and parameter payload
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      axis_sel      <= '0;
      axis_dir_down <= 1'b0;
      param_num     <= 8'h00;
      param_data    <= 32'h0000_0000;
      point_idx     <= 8'h00;
    end else begin
      if (state == ST_CHECK) begin
        axis_sel      <= cmd_axis;
        axis_dir_down <= is_down;
        point_idx     <= accu[7:0];
      end
      if (next_state == ST_LOAD) begin
        // Velocity is passed on unscaled, in microsteps per second
        param_num  <= is_rot ? PAR_TGT_VEL : PAR_TGT_POS;
        param_data <= is_rot ? accu : next_target;
      end
    end
  end

  // Reply request toward the reply builder
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lnk.rep_done   <= 1'b0;
      lnk.rep_status <= 8'h00;
      lnk.rep_instr  <= 8'h00;
    end else begin
      lnk.rep_done <= next_state == ST_REPLY;
      if (state == ST_CHECK) begin
        lnk.rep_status <= next_status;
        lnk.rep_instr  <= cur_instr;
      end
    end
  end

  // Software registers; a drop event wins over its clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      accu        <= ACCU_RST;
      xreg        <= XREG_RST;
      dropped     <= 1'b0;
      last_status <= 8'h00;
      last_instr  <= 8'h00;
      frame_count <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == OFS_ACCU) begin
        accu <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFS_XREG) begin
        xreg <= reg_wdata;
      end
      if (lnk.frm_valid && state != ST_IDLE) begin
        dropped <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_STAT && reg_wdata[STAT_DROP_BIT]) begin
        dropped <= 1'b0;
      end
      if (state == ST_CHECK) begin
        last_status <= next_status;
        last_instr  <= cur_instr;
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_ACCU:   reg_rdata <= accu;
        OFS_XREG:   reg_rdata <= xreg;
        OFS_STAT: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[STAT_DROP_BIT] <= dropped;
          reg_rdata[STAT_BUSY_BIT] <= state != ST_IDLE;
          reg_rdata[STAT_CODE_LSB +: 8] <= last_status;
          reg_rdata[STAT_INSTR_LSB +: 8] <= last_instr;
        end
        OFS_TARGET: reg_rdata <= param_data;
        OFS_COUNT:  reg_rdata <= {16'h0000, frame_count};
        default:    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic ok_now;
  assign ok_now = state == ST_CHECK && next_status == STS_OK;

  sequence s_rot_steps;
    axis_vel_mode && pos_abort ##1 param_wr && param_num == PAR_TGT_VEL
      && param_data == $past(accu) ##1 lnk.rep_done;
  endsequence

  sequence s_move_steps;
    param_wr && param_num == PAR_TGT_POS ##1 lnk.rep_done;
  endsequence

  AST_ROT_ORDER: assert property (ok_now && is_rot |=> s_rot_steps)
    else $error("rotate did not select mode before loading velocity");
  AST_ROT_ABORT: assert property ($rose(param_wr) && param_num == PAR_TGT_VEL
                                  |-> $past(pos_abort))
    else $error("velocity load without positioning abort");
  AST_DOWN_DIR: assert property (ok_now && is_down |=> axis_dir_down)
    else $error("downward rotate not flagged down");
  AST_UP_DIR: assert property (ok_now && is_rot && !is_down |=> !axis_dir_down)
    else $error("upward rotate flagged down");
  AST_X_AXIS: assert property (ok_now && (is_move || is_rot_idx)
                               |=> axis_sel == $past(xreg[AXIS_W-1:0]))
    else $error("indexed command used wrong axis");
  AST_MOVE_LOAD: assert property (ok_now && is_move && cur_type != TGT_STORED
                                  |=> s_move_steps)
    else $error("move did not write target position");
  AST_OFFSET_SUM: assert property (ok_now && is_move && cur_type == TGT_OFFSET
                                   |=> param_data == $past(act_sel) + $past(accu))
    else $error("offset target not actual plus value");
  AST_REPLY_SOON: assert property (frame_take |-> ##[2:5] lnk.rep_done)
    else $error("reply not issued in time");
  AST_BAD_SUM: assert property (frame_take && !lnk.frm_sum_ok
                                |=> !axis_vel_mode && !param_wr [*3])
    else $error("command executed despite bad checksum");
  AST_OK_CODE: assert property (ok_now |-> ##[2:4] lnk.rep_done
                                && lnk.rep_status == STS_OK)
    else $error("good command not answered with OK");
endmodule

// file: verification/mcd_axis_model.sv
// Axis-side partner: actual positions, stored points, command capture
module mcd_axis_model (
  input  logic              ref_clk,
  input  logic [7:0]        point_idx,
  input  logic              axis_vel_mode,
  input  logic              pos_abort,
  input  logic              param_wr,
  input  logic [7:0]        param_num,
  output logic [6*32-1:0]   act_pos_flat,
  output logic [31:0]       point_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int   vel_cnt   = 0;
  int   abort_cnt = 0;
  int   order_bad = 0;
  logic vel_armed = 1'b0;

  // Axis 0 near the top of the range, so its offset moves wrap past zero; axes 1 to 5 start just above zero
  initial begin
    for (int n = 0; n < 6; n++) begin
      act_pos_flat[32*n +: 32] = 32'hFFFF_FF00 + 32'(n * 16'h1111);
    end
  end

  // Point table, combinational from the index as the core expects
  assign point_data = {8'hC3, point_idx, 16'h5AA5};

  // Velocity write only counts once the mode switch came before it
  always @(posedge ref_clk) begin
    if (param_wr === 1'b1 && param_num === 8'h02) begin
      if (vel_armed !== 1'b1) order_bad++;
      vel_armed = 1'b0;
    end
    if (axis_vel_mode === 1'b1) begin
      vel_cnt++;
      vel_armed = 1'b1;
    end
    if (pos_abort === 1'b1) abort_cnt++;
  end
endmodule

// file: verification/mcd_decoder_test.sv
// Self-checking bench for the motion command decoder
module mcd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mcd_pkg::*;
  logic              ref_clk = 1'b0;
  logic              resetn  = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic [6*32-1:0]   act_pos_flat;
  logic [31:0]       point_data;
  logic [7:0]        point_idx;
  logic              axis_vel_mode, axis_dir_down, pos_abort, param_wr, reply_valid;
  logic [AXIS_W-1:0] axis_sel;
  logic [7:0]        param_num;
  logic [31:0]       param_data;
  logic [71:0]       reply_frame;
  int                n_fail = 0;
  int                checks = 0;
  logic [31:0]       seed = 32'hDFBD1AF4;
  logic [71:0]       exp_rep[$];
  logic [42:0]       exp_wr[$];

  always #4 ref_clk = ~ref_clk;

  mcd_decoder mcd_decoder_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .act_pos_flat(act_pos_flat), .point_data(point_data), .point_idx(point_idx),
    .axis_vel_mode(axis_vel_mode), .axis_dir_down(axis_dir_down), .pos_abort(pos_abort),
    .axis_sel(axis_sel), .param_wr(param_wr), .param_num(param_num),
    .param_data(param_data), .reply_valid(reply_valid), .reply_frame(reply_frame));

  mcd_axis_model mcd_axis_model_inst (.ref_clk(ref_clk), .point_idx(point_idx),
    .axis_vel_mode(axis_vel_mode), .pos_abort(pos_abort), .param_wr(param_wr),
    .param_num(param_num), .act_pos_flat(act_pos_flat), .point_data(point_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reply as the host should see it: host, module, status, code, value, sum
  function automatic logic [71:0] reply(input logic [7:0] sts, input logic [7:0] ins);
    logic [7:0] s;
    s = 8'h02 + 8'h01 + sts + ins;
    return {8'h02, 8'h01, sts, ins, 32'h0, s};
  endfunction

  task automatic send(input logic [7:0] tgt, ins, typ, mot, input logic [31:0] v,
                      input logic bad, dup);
    logic [7:0] b[9];
    b = '{tgt, ins, typ, mot, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int k = 0; k < 8; k++) b[8] = b[8] + b[k];
    if (bad) b[8] = b[8] ^ 8'h5A;
    for (int k = 0; k < 9; k++) wr(8'(4 * k), {24'h0, b[k]});
    // A second submit while busy must be dropped, not answered
    if (dup) wr(OFS_FRAME8, {24'h0, b[8]});
    // Wait up to 12 cycles for the queued reply, then 2 more cycles before the next command
    for (int n = 0; n < 12 && exp_rep.size() != 0; n++) @(posedge ref_clk);
    check("reply pending", 72'(exp_rep.size()), 72'h0);
    repeat (2) @(posedge ref_clk);
  endtask

  // Every reply and parameter write of the core is compared against the queued model
  always @(posedge ref_clk) begin
    if (reply_valid === 1'b1) check("reply", reply_frame, exp_rep.size() ? exp_rep.pop_front() : 'x);
    if (param_wr === 1'b1) check("param", 72'({param_num, axis_sel, param_data}),
      72'(exp_wr.size() ? exp_wr.pop_front() : 'x));
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    logic [31:0] d, acc, x;
    logic [7:0]  ins, mot;
    int          vc, ac;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFS_ACCU, d); check("accu reset", 72'(d), 72'(ACCU_RST));
    rd(OFS_XREG, d); check("xreg reset", 72'(d), 72'(XREG_RST));
    rd(8'h3C, d); check("unmapped", 72'(d), 72'h0);
    $display("test registers done");
    // Rotations, two by motor field and two by X register
    for (int i = 0; i < 4; i++) begin
      ins = 8'h32 + 8'(i);
      acc = rnd() & 32'h7FFF_FFFF;
      x   = rnd() % 6;
      mot = 8'(rnd() % 6);
      wr(OFS_ACCU, acc);
      wr(OFS_XREG, x);
      rd(OFS_ACCU, d); check("accu", 72'(d), 72'(acc));
      vc = mcd_axis_model_inst.vel_cnt;
      ac = mcd_axis_model_inst.abort_cnt;
      exp_wr.push_back({PAR_TGT_VEL, (i < 2) ? mot[2:0] : x[2:0], acc});
      exp_rep.push_back(reply(STS_OK, ins));
      send(8'h01, ins, 8'(rnd()), mot, rnd(), 1'b0, 1'b0);
      check("down", 72'(axis_dir_down), 72'(i % 2 == 0));
      check("vel mode", 72'(mcd_axis_model_inst.vel_cnt), 72'(vc + 1));
      check("abort", 72'(mcd_axis_model_inst.abort_cnt), 72'(ac + 1));
    end
    check("order", 72'(mcd_axis_model_inst.order_bad), 72'h0);
    $display("test rotate done");
    // Moves by X register: absolute, offset (wraps on axis 0 only), stored point
    for (int t = 0; t < 3; t++) begin
      acc = rnd() & 32'h7FFF_FFFF;
      x   = rnd() % 6;
      wr(OFS_ACCU, acc);
      wr(OFS_XREG, x);
      vc = mcd_axis_model_inst.vel_cnt;
      d  = (t == 0) ? acc : (t == 1) ? act_pos_flat[32*x +: 32] + acc
                                     : {8'hC3, acc[7:0], 16'h5AA5};
      exp_wr.push_back({PAR_TGT_POS, x[2:0], d});
      exp_rep.push_back(reply(STS_OK, INS_MOVE_IDX));
      send(8'h01, INS_MOVE_IDX, 8'(t), 8'(rnd()), rnd(), 1'b0, 1'b0);
      check("move no vel", 72'(mcd_axis_model_inst.vel_cnt), 72'(vc));
    end
    rd(OFS_TARGET, acc);
    check("target", 72'(acc), 72'(d));
    $display("test move done");
    // Bad sum, then the status register read back
    vc = mcd_axis_model_inst.vel_cnt;
    exp_rep.push_back(reply(STS_BAD_SUM, INS_UP_ACCU));
    send(8'h01, INS_UP_ACCU, 8'h00, 8'h00, 32'h0, 1'b1, 1'b0);
    rd(OFS_STAT, d);
    check("status", 72'(d[23:0]), 72'({INS_UP_ACCU, STS_BAD_SUM, 8'h00}));
    // Unknown code answered, its early resubmit dropped
    exp_rep.push_back(reply(STS_BAD_CMD, 8'h36));
    send(8'h01, 8'h36, 8'h00, 8'h00, 32'h0, 1'b0, 1'b1);
    rd(OFS_STAT, d);
    check("dropped", 72'(d[1:0]), 72'h1);
    wr(OFS_STAT, 32'h0000_0001);
    rd(OFS_STAT, d);
    check("drop clear", 72'(d[1:0]), 72'h0);
    // Type above stored point, then motor field past the last axis
    exp_rep.push_back(reply(STS_BAD_TYPE, INS_MOVE_IDX));
    send(8'h01, INS_MOVE_IDX, 8'h03, 8'h00, 32'h0, 1'b0, 1'b0);
    exp_rep.push_back(reply(STS_BAD_VALUE, INS_DOWN_ACCU));
    send(8'h01, INS_DOWN_ACCU, 8'h00, 8'h06, 32'h0, 1'b0, 1'b0);
    check("no vel", 72'(mcd_axis_model_inst.vel_cnt), 72'(vc));
    send(8'h07, INS_DOWN_IDX, 8'h00, 8'h00, 32'h0, 1'b0, 1'b0);
    rd(OFS_COUNT, d); check("count", 72'(d[15:0]), 72'(16'h000B));
    check("queues", 72'(exp_wr.size() + exp_rep.size()), 72'h0);
    $display("test refuse done");
    stop_test();
  end
endmodule
